// ### logic/ptc_timer.sv
// Operation
// RULE1: two-bit mode selects compare, capture, pwm, timer
// RULE2: software stops timer before changing mode
// RULE3: compare match drives pin: hold, low, high, toggle
// RULE4: pwm pin function: inactive, active, pwm, pulse
// RULE5: capture edge: rising, falling, both, disabled
// RULE6: timer mode ignores pin function, no pin
// RULE7: match to level equal initial shows nothing
// RULE8: run rising edge restores initial pin level
// RULE9: software alters pwm pin function only stopped
// RULE10: output-control bit sets initial or active level
// RULE11: polarity bit inverts pin, not timer mode
// RULE12: capture source: capture pin or clock pin
// RULE13: clear source: period/overflow or compare a
// RULE14: overflow clears only when period is zero
// RULE15: clear source ignored outside compare, timer
// RULE16: counter read-only via low/high bytes, reset zero
// RULE17: narrow high bytes read zero above width
// RULE18: compare a pair read/write, resets zero
// RULE19: period pair read/write, resets zero
// RULE20: low bytes pass through shared 8-bit buffer
// RULE21: run rise zeroes counter, fall holds count
// RULE22: match acts on pin in same edge
//
// Added by the designer: the address map and the APB slave port.
module ptc_timer #(
   parameter int count_width = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_input_pin,
   input  wire logic        external_clock_pin,
   output logic             timer_output_pin,
   output logic             pin_enabled,
   output logic             capture_event,
   output logic             match_a_event,
   output logic             match_p_event
);
   localparam int cw = count_width;
   localparam logic [cw-1:0] max_count = {cw{1'b1}};
   localparam logic [cw-1:0] zero_count = '0;

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [7:0]    mode_control;
      logic          run;
      logic          run_q;
      logic [cw-1:0] count;
      logic [cw-1:0] cmpa;
      logic [cw-1:0] period;
      logic [cw-1:0] captured;
      logic [7:0]    low_buffer;
      logic          raw_pin;
      logic [2:0]    cap_sync;
      logic [2:0]    clk_sync;
      logic          cap_level;
      logic          clk_level;
      logic [31:0]   rdata;
      logic          cap_ev;
      logic          ma_ev;
      logic          mp_ev;
   } ptc_state_type;

   ptc_state_type st;
   ptc_state_type next_st;

   function automatic logic [7:0] high_byte(input logic [cw-1:0] v);
      logic [15:0] w;
      w = 16'(v);
      return w[15:8]; // narrow widths leave upper bits zero [RULE17]
   endfunction

   // the three high-byte registers share the buffer side effect
   function automatic logic high_adr(input logic [4:0] a);
      return a == ptc_pkg::adr_count_high || a == ptc_pkg::adr_cmpa_high
         || a == ptc_pkg::adr_period_high;
   endfunction

   logic [4:0]  addr;
   logic        addr_hit;
   logic        counting;
   logic        wr_en;
   logic        rd_en;
   logic [1:0]  mode;
   logic [1:0]  pin_fn;
   logic        init_lvl;
   logic        run_rise;
   logic        match_a;
   logic        match_p;
   logic        overflow;
   logic        cap_src;
   logic        cap_rise;
   logic        cap_fall;
   logic        capture_now;
   logic        clear_now;
   logic        pwm_level;
   logic        drive_level;
   logic [cw-1:0] wide_word;

   assign addr     = paddr[4:0];
   // only the low five address bits pick a register; anything above them
   // must be zero, otherwise the word would alias onto the register with the same low five bits
   assign addr_hit = (paddr[31:5] == 27'h0000000);
   assign wr_en    = psel & penable & pwrite & addr_hit;
   // reads are decoded in the setup cycle so that the registered read data
   // already stands in the access cycle, when the master samples it
   assign rd_en    = psel & ~penable & ~pwrite & addr_hit;
   assign mode     = st.mode_control[ptc_pkg::pos_mode_hi:ptc_pkg::pos_mode_lo]; // [RULE1]
   assign pin_fn   = st.mode_control[ptc_pkg::pos_pin_hi:ptc_pkg::pos_pin_lo];
   assign init_lvl = st.mode_control[ptc_pkg::pos_init_lvl];
   assign cap_src  = st.mode_control[ptc_pkg::pos_cap_src];
   assign run_rise = st.run & ~st.run_q;
   // the start cycle still shows the old count, so it must not match
   assign counting = st.run & st.run_q;

   // ***********************************************************
   // comparators
   // ***********************************************************
   assign match_a  = counting && (st.count == st.cmpa);
   assign match_p  = counting && (st.count == st.period) && (st.period != zero_count);
   assign overflow = counting && (st.count == max_count);

   always_comb begin
      logic src_level;
      logic src_mid;
      logic src_last;
      src_level = cap_src ? st.clk_level : st.cap_level; // [RULE12]
      src_mid   = cap_src ? st.clk_sync[1] : st.cap_sync[1];
      src_last  = cap_src ? st.clk_sync[2] : st.cap_sync[2];
      // an edge counts once the last two stages agree on a new level
      cap_rise = (src_mid == src_last) & src_last & ~src_level;
      cap_fall = (src_mid == src_last) & ~src_last & src_level;
      unique case (pin_fn) // [RULE5]
         ptc_pkg::pin_fn_0: capture_now = cap_rise;
         ptc_pkg::pin_fn_1: capture_now = cap_fall;
         ptc_pkg::pin_fn_2: capture_now = cap_rise | cap_fall;
         ptc_pkg::pin_fn_3: capture_now = 1'b0;
      endcase
      if (mode != ptc_pkg::mode_capture) begin
         capture_now = 1'b0;
      end
   end

   always_comb begin
      clear_now = 1'b0;
      if (mode == ptc_pkg::mode_compare || mode == ptc_pkg::mode_timer) begin
         if (st.mode_control[ptc_pkg::pos_clr_src]) begin // [RULE13]
            clear_now = match_a;
         end else begin
            // overflow only counts as a clear source when period is all zeros [RULE14]
            clear_now = match_p | (overflow & (st.period == zero_count));
         end
      end else if (mode == ptc_pkg::mode_pwm) begin
         clear_now = match_p | (overflow & (st.period == zero_count)); // [RULE15]
      end
   end

   // duty compare: count below cmpa is active; cmpa above period gives full duty
   assign pwm_level = (st.count < st.cmpa) ? init_lvl : ~init_lvl;

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      next_st        = st;
      next_st.run_q  = st.run;
      next_st.cap_sync = {st.cap_sync[1:0], capture_input_pin};
      next_st.clk_sync = {st.clk_sync[1:0], external_clock_pin};
      // a level only counts once the second and third stage agree
      if (st.cap_sync[1] == st.cap_sync[2]) begin
         next_st.cap_level = st.cap_sync[2];
      end
      if (st.clk_sync[1] == st.clk_sync[2]) begin
         next_st.clk_level = st.clk_sync[2];
      end
      next_st.cap_ev = capture_now;
      next_st.ma_ev  = match_a;
      next_st.mp_ev  = match_p;
      wide_word      = zero_count;

      if (run_rise) begin
         next_st.count = zero_count; // [RULE21]
      end else if (st.run) begin
         next_st.count = clear_now ? zero_count : st.count + cw'(1);
      end // stopped run holds the count [RULE21]
      if (capture_now) begin
         next_st.captured = st.count;
      end

      // compare match pin action on the very edge of the match [RULE22]
      if (run_rise) begin
         next_st.raw_pin = init_lvl; // [RULE8]
      end else if (mode == ptc_pkg::mode_compare && match_a) begin
         unique case (pin_fn) // [RULE3]
            ptc_pkg::pin_fn_0: next_st.raw_pin = st.raw_pin;
            ptc_pkg::pin_fn_1: next_st.raw_pin = 1'b0; // equal to initial stays put [RULE7]
            ptc_pkg::pin_fn_2: next_st.raw_pin = 1'b1;
            ptc_pkg::pin_fn_3: next_st.raw_pin = ~st.raw_pin;
         endcase
      end else if (mode == ptc_pkg::mode_pwm) begin
         unique case (pin_fn) // [RULE4] [RULE10]
            ptc_pkg::pin_fn_0: next_st.raw_pin = ~init_lvl;
            ptc_pkg::pin_fn_1: next_st.raw_pin = init_lvl;
            ptc_pkg::pin_fn_2: next_st.raw_pin = pwm_level;
            ptc_pkg::pin_fn_3: next_st.raw_pin = st.run ? init_lvl : ~init_lvl;
         endcase
      end
      // single pulse ends on compare a, which clears run
      if (mode == ptc_pkg::mode_pwm && pin_fn == ptc_pkg::pin_fn_3 && match_a
          && !run_rise) begin
         next_st.run = 1'b0;
      end

      if (wr_en) begin
         unique case (addr)
            ptc_pkg::adr_mode_control: next_st.mode_control = pwdata[7:0];
            ptc_pkg::adr_run_control:  next_st.run = pwdata[ptc_pkg::pos_run_bit];
            ptc_pkg::adr_cmpa_low,
            ptc_pkg::adr_period_low:   next_st.low_buffer = pwdata[7:0]; // [RULE20]
            ptc_pkg::adr_cmpa_high: begin
               wide_word = cw'({pwdata[7:0], st.low_buffer});
               next_st.cmpa = wide_word; // [RULE18] [RULE20]
            end
            ptc_pkg::adr_period_high: begin
               wide_word = cw'({pwdata[7:0], st.low_buffer});
               next_st.period = wide_word; // [RULE19] [RULE20]
            end
            default: ;
         endcase
      end

      // buffer loads in the same edge as the high byte, so both halves match
      next_st.rdata = '0;
      if (rd_en) begin
         unique case (addr)
            ptc_pkg::adr_mode_control: next_st.rdata = {24'h000000, st.mode_control};
            ptc_pkg::adr_run_control:  next_st.rdata = {31'h00000000, st.run};
            ptc_pkg::adr_count_high: begin
               // capture mode reads the latched value, otherwise the live count
               wide_word = (mode == ptc_pkg::mode_capture) ? st.captured : st.count;
               next_st.rdata = {24'h000000, high_byte(wide_word)}; // [RULE16]
               next_st.low_buffer = wide_word[7:0]; // [RULE20]
            end
            ptc_pkg::adr_cmpa_high: begin
               next_st.rdata = {24'h000000, high_byte(st.cmpa)};
               next_st.low_buffer = st.cmpa[7:0];
            end
            ptc_pkg::adr_period_high: begin
               next_st.rdata = {24'h000000, high_byte(st.period)};
               next_st.low_buffer = st.period[7:0];
            end
            ptc_pkg::adr_count_low,
            ptc_pkg::adr_cmpa_low,
            ptc_pkg::adr_period_low:   next_st.rdata = {24'h000000, st.low_buffer};
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign pin_enabled = (mode != ptc_pkg::mode_timer) && (mode != ptc_pkg::mode_capture); // [RULE6]
   assign drive_level = st.mode_control[ptc_pkg::pos_invert] ? ~st.raw_pin : st.raw_pin; // [RULE11]
   assign timer_output_pin = pin_enabled ? drive_level : 1'b0;
   assign prdata        = st.rdata;
   assign pready        = 1'b1;
   assign pslverr       = 1'b0;
   assign capture_event = st.cap_ev;
   assign match_a_event = st.ma_ev;
   assign match_p_event = st.mp_ev;

   // ***********************************************************
   // checks
   // ***********************************************************
   a_run_clears_count: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
      $rose(st.run) |=> st.count == zero_count) else $error("count not zero after start");
   a_stop_holds_count: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
      (!st.run && !st.run_q) |=> $stable(st.count)) else $error("stopped count moved");
   a_run_sets_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      (run_rise && mode == ptc_pkg::mode_compare) |=> st.raw_pin == $past(init_lvl))
      else $error("pin not at initial level");
   a_toggle_on_match: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      (!run_rise && match_a && mode == ptc_pkg::mode_compare && pin_fn == ptc_pkg::pin_fn_3)
      |=> st.raw_pin != $past(st.raw_pin)) else $error("toggle missed");
   a_timer_no_pin: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      mode == ptc_pkg::mode_timer |-> !timer_output_pin) else $error("timer mode drives pin");
   a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
      (st.run && !run_rise && match_a && mode == ptc_pkg::mode_compare
       && st.mode_control[ptc_pkg::pos_clr_src]) |=> st.count == zero_count)
      else $error("compare a did not clear");
   a_high_commits: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
      (wr_en && addr == ptc_pkg::adr_period_high) |=> st.period[7:0] == $past(st.low_buffer))
      else $error("low byte not committed");
   a_capture_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      (mode == ptc_pkg::mode_capture && pin_fn == ptc_pkg::pin_fn_3) |=> !capture_event)
      else $error("capture while disabled");
   a_read_stands: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
      (prdata != 32'h00000000) |-> (psel && penable && !pwrite))
      else $error("read data outside access");
   a_mode_readback: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      (psel && penable && !pwrite && paddr == 32'(ptc_pkg::adr_mode_control))
      |-> prdata == {24'h000000, $past(st.mode_control)})
      else $error("mode control read back wrong");
   a_narrow_high: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
      (psel && penable && !pwrite && addr_hit && high_adr(addr))
      |-> (prdata >> (cw - 8)) == 32'h00000000)
      else $error("unimplemented high bits set");
   a_low_write_buffers: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
      (wr_en && addr == ptc_pkg::adr_cmpa_low)
      |=> st.low_buffer == $past(pwdata[7:0]) && $stable(st.cmpa))
      else $error("low byte write went past the buffer");
   a_pulse_stops_run: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      (mode == ptc_pkg::mode_pwm && pin_fn == ptc_pkg::pin_fn_3 && match_a && !wr_en)
      |=> !st.run) else $error("single pulse did not stop");
   a_pwm_forced: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      (mode == ptc_pkg::mode_pwm && !pin_fn[1] && !run_rise)
      |=> st.raw_pin == ($past(pin_fn[0]) ? $past(init_lvl) : !$past(init_lvl)))
      else $error("forced pwm level wrong");
   a_pwm_start_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      (run_rise && mode == ptc_pkg::mode_pwm) |=> st.raw_pin == $past(init_lvl))
      else $error("pwm start not at initial level");
   a_capture_edge: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      (mode == ptc_pkg::mode_capture && pin_fn == ptc_pkg::pin_fn_1 && cap_rise)
      |=> !capture_event) else $error("rising edge captured in falling mode");
   a_period_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
      (match_p && mode == ptc_pkg::mode_timer && !st.mode_control[ptc_pkg::pos_clr_src])
      |=> st.count == zero_count) else $error("period match did not clear");
   a_sync_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      (st.cap_sync[1] != st.cap_sync[2]) |=> $stable(st.cap_level))
      else $error("capture level moved before stages agreed");
endmodule // ptc_timer

// ### logic/ptc_pkg.sv
package ptc_pkg;
   // ***********************************************************
   // register map (byte addresses, one aligned word each)
   // ***********************************************************
   localparam logic [4:0] adr_mode_control = 5'h00;
   localparam logic [4:0] adr_run_control  = 5'h04;
   localparam logic [4:0] adr_count_low    = 5'h08;
   localparam logic [4:0] adr_count_high   = 5'h0c;
   localparam logic [4:0] adr_cmpa_low     = 5'h10;
   localparam logic [4:0] adr_cmpa_high    = 5'h14;
   localparam logic [4:0] adr_period_low   = 5'h18;
   localparam logic [4:0] adr_period_high  = 5'h1c;

   // ***********************************************************
   // mode control field positions
   // ***********************************************************
   localparam int pos_mode_hi   = 7;
   localparam int pos_mode_lo   = 6;
   localparam int pos_pin_hi    = 5;
   localparam int pos_pin_lo    = 4;
   localparam int pos_init_lvl  = 3;
   localparam int pos_invert    = 2;
   localparam int pos_cap_src   = 1;
   localparam int pos_clr_src   = 0;
   localparam int pos_run_bit   = 0;

   localparam logic [7:0] mode_control_reset = 8'h00;

   localparam logic [1:0] mode_compare = 2'h0;
   localparam logic [1:0] mode_capture = 2'h1;
   localparam logic [1:0] mode_pwm     = 2'h2;
   localparam logic [1:0] mode_timer   = 2'h3;

   localparam logic [1:0] pin_fn_0 = 2'h0;
   localparam logic [1:0] pin_fn_1 = 2'h1;
   localparam logic [1:0] pin_fn_2 = 2'h2;
   localparam logic [1:0] pin_fn_3 = 2'h3;
endpackage

// ### bench/ptc_pin_model.sv
module ptc_pin_model (
   input  wire logic pclk,
   input  wire logic go_cap,
   input  wire logic go_clk,
   output logic      capture_input_pin,
   output logic      external_clock_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // pins idle low, one clean pulse per request
   // ***************************************************
   initial capture_input_pin = 1'b0;
   initial external_clock_pin = 1'b0;
   always begin
      @(posedge pclk);
      if (go_cap === 1'b1) begin
         capture_input_pin <= 1'b1;
         repeat (8) @(posedge pclk);
         capture_input_pin <= 1'b0;
      end
   end
   always begin
      @(posedge pclk);
      if (go_clk === 1'b1) begin
         external_clock_pin <= 1'b1;
         repeat (8) @(posedge pclk);
         external_clock_pin <= 1'b0;
      end
   end
endmodule // ptc_pin_model

// ### bench/tb_ptc_timer.sv
module tb_ptc_timer;
   timeunit 1ns;
   timeprecision 1ps;
   // narrow width exercises the unimplemented high bits
   localparam int cw = 10;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, cap_pin, clk_pin, pin, pin_en, ev_c, ev_a, ev_p;
   logic        go_cap = 1'b0;
   logic        go_clk = 1'b0;
   logic        lvl, e;
   logic [31:0] seed = 32'h10d486ff;
   logic [31:0] al [9];
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_cap = 0;
   int n_ma = 0;
   int n_mp = 0;
   int m_mode = 0;
   int m_run = 0;
   int m_buf = 0;
   int m_cmpa = 0;
   int m_per = 0;
   int wm = (1 << cw) - 1;
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      n_cap = n_cap + (ev_c === 1'b1);
      n_ma = n_ma + (ev_a === 1'b1);
      n_mp = n_mp + (ev_p === 1'b1);
   end
   ptc_timer #(.count_width(cw)) u_ptc_timer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
      .external_clock_pin(clk_pin), .timer_output_pin(pin), .pin_enabled(pin_en),
      .capture_event(ev_c), .match_a_event(ev_a), .match_p_event(ev_p));
   ptc_pin_model u_ptc_pin_model (.pclk(pclk), .go_cap(go_cap), .go_clk(go_clk),
      .capture_input_pin(cap_pin), .external_clock_pin(clk_pin));
   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_word(input string w, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", w, x, g);
      end
   endtask
   task automatic chk_bit(input string w, input logic x, input logic g);
      samples_checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("unexpected %s expected %b seen %b", w, x, g);
      end
   endtask
   // starts after the next rising edge; read data is taken at the edge that sees pready
   task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      chk_bit("slave error", 1'b0, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
      case (a)
         ptc_pkg::adr_mode_control: m_mode = d[7:0];
         ptc_pkg::adr_run_control: m_run = d[0];
         ptc_pkg::adr_cmpa_low, ptc_pkg::adr_period_low: m_buf = d[7:0];
         ptc_pkg::adr_cmpa_high: m_cmpa = {d[7:0], m_buf[7:0]} & wm;
         ptc_pkg::adr_period_high: m_per = {d[7:0], m_buf[7:0]} & wm;
         default: ;
      endcase
   endtask
   // count is only read while it is known to be zero
   task automatic rd(input logic [31:0] a);
      logic [31:0] r;
      int x;
      apb(1'b0, a, 32'h0, r);
      x = 0;
      case (a)
         ptc_pkg::adr_mode_control: x = m_mode;
         ptc_pkg::adr_run_control: x = m_run;
         ptc_pkg::adr_count_high: m_buf = 0;
         ptc_pkg::adr_count_low, ptc_pkg::adr_cmpa_low, ptc_pkg::adr_period_low: x = m_buf;
         ptc_pkg::adr_cmpa_high: {x, m_buf} = {m_cmpa >> 8, m_cmpa & 255};
         ptc_pkg::adr_period_high: {x, m_buf} = {m_per >> 8, m_per & 255};
         default: ;
      endcase
      chk_word("read data", x, r);
   endtask
   task automatic run_case(input logic [1:0] md, fn, input logic il, iv, input logic [1:0] sc);
      wr(ptc_pkg::adr_run_control, 32'h0);
      wr(ptc_pkg::adr_mode_control, {24'h0, md, fn, il, iv, sc});
      wr(ptc_pkg::adr_run_control, 32'h1);
      repeat (2) @(negedge pclk);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      stop_test();
   end
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      al = '{32'h0, 32'h4, 32'hc, 32'h8, 32'h14, 32'h10, 32'h1c, 32'h18, 32'h20};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         foreach (al[k]) rd(al[k]);
         for (int k = 4; k < 8; k++) wr(al[k ^ 1], xs());
         wr(32'h8, xs());
         wr(32'hc, xs());
         wr(32'h20, xs());
         wr(32'h0, xs() & 32'hff);
      end
      $display("test registers done");
      wr(32'h10, 32'd20);
      wr(32'h14, 32'h0);
      wr(32'h18, 32'd100);
      wr(32'h1c, 32'h0);
      for (int f = 0; f < 4; f++) for (int v = 0; v < 2; v++) begin
         lvl = xs() & 1;
         run_case(ptc_pkg::mode_compare, f[1:0], lvl, v[0], 2'b00);
         chk_bit("pin initial", lvl ^ v[0], pin);
         chk_bit("pin enabled", 1'b1, pin_en);
         for (int k = 0; k < 300 && ev_a !== 1'b1; k++) @(negedge pclk);
         e = (f == 0) ? lvl : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : ~lvl;
         chk_bit("pin on match", e ^ v[0], pin);
         run_case(ptc_pkg::mode_pwm, f[1:0], lvl, v[0], 2'b00);
         repeat (5) @(negedge pclk);
         chk_bit("pwm early", ((f == 0) ? ~lvl : lvl) ^ v[0], pin);
         repeat (30) @(negedge pclk);
         chk_bit("pwm late", ((f == 1) ? lvl : ~lvl) ^ v[0], pin);
         if (f == 3) m_run = 0;
         if (f == 3) rd(ptc_pkg::adr_run_control);
      end
      $display("test pin functions done");
      for (int c = 0; c < 2; c++) begin
         run_case(ptc_pkg::mode_timer, 2'h3, 1'b1, 1'b1, {1'b0, c[0]});
         chk_bit("timer pin enabled", 1'b0, pin_en);
         chk_bit("timer pin", 1'b0, pin);
         {n_ma, n_mp} = '0;
         repeat (300) @(posedge pclk);
         chk_word("p match seen", 32'(c == 0), 32'(n_mp > 0));
         chk_word("a match seen", 32'h1, 32'(n_ma > 1));
      end
      $display("test clear source done");
      for (int s = 0; s < 2; s++) for (int f = 0; f < 4; f++) begin
         run_case(ptc_pkg::mode_capture, f[1:0], 1'b0, 1'b0, {s[0], 1'b1});
         n_cap = 0;
         for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            if ((p ^ s) == 0) go_clk <= 1'b1;
            else go_cap <= 1'b1;
            @(posedge pclk);
            {go_cap, go_clk} <= 2'b00;
            repeat (40) @(posedge pclk);
            if (p == 0) chk_word("foreign pin", 32'h0, n_cap);
         end
         chk_word("captures", (f == 3) ? 0 : (f == 2) ? 2 : 1, n_cap);
      end
      $display("test capture done");
      stop_test();
   end
endmodule // tb_ptc_timer
